// ### inc/adc_timing_defines.vh
// Constants for the converter prescaler and conversion timing block
`ifndef ADC_TIMING_DEFINES_VH
`define ADC_TIMING_DEFINES_VH

// Prescale select field
`define PSEL_W          3
`define PSEL_RST        3'h0
// Prescaler counter width (largest ratio 128)
`define PCNT_W          7
`define PCNT_RST        7'h00
// Conversion lengths in converter clock cycles
`define CONV_NORMAL     5'h0d
`define CONV_FIRST      5'h19
`define CCNT_W          5
`define CCNT_RST        5'h00
// Lowest supported CPU clock, in kHz
`define CPU_MIN_KHZ     100

`endif

// ### rtl/adc_conv_timing.v
// Converter prescaler and conversion sequencing top
//
// Function
// [R01] Prescaler makes converter clock above 100kHz CPU
// [R02] Division ratio chosen by prescale select
// [R03] Prescaler starts counting when enable sets
// [R04] Prescaler runs while enabled, reset otherwise
// [R05] Start begins at next converter clock edge
// [R06] Normal conversion lasts 13 converter clocks
// [R07] First conversion after enable lasts 25
// [R08] Software keeps converter clock 50 to 200kHz
// [R09] Start bit reads one while converting
// [R10] Ratio ladder codes map to 2..128
`timescale 1ns/1ns
`include "adc_timing_defines.vh"

module adc_conv_timing (
    // Clock, reset and enable
    input  wire                core_clk_i,
    input  wire                sys_rst_i,
    input  wire                clk_en_i,
    // Control bits from software
    input  wire                converter_enable_i,
    input  wire [`PSEL_W-1:0]  prescale_select_i,
    input  wire                conversion_start_i,
    // Status and sampling core controls
    output reg                 conversion_start_o,
    output reg                 converting_o,
    output reg                 first_conv_o,
    output reg                 conv_done_o,
    output reg                 adc_clk_o
);

    localparam IDLE    = 3'b001;
    localparam WAITING = 3'b010;
    localparam CONVERT = 3'b100;

    reg  [2:0]          state_reg;
    reg  [2:0]          state_next;
    reg  [`CCNT_W-1:0]  cnt_reg;
    reg  [`CCNT_W-1:0]  cnt_next;
    reg                 first_reg;
    reg                 first_next;
    reg                 done_next;
    wire                tick;

    // [R01] Prescaler instance
    // [R03] Runs from the enable
    // [R04] Held cleared when off
    adc_prescaler u_prescaler (
        .core_clk_i        (core_clk_i),
        .sys_rst_i         (sys_rst_i),
        .clk_en_i          (clk_en_i),
        .run_i             (converter_enable_i),
        .prescale_select_i (prescale_select_i),
        .tick_o            (tick)
    );

    // Sequencer next state
    always @* begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        first_next = first_reg;
        done_next  = 1'b0;
        case (state_reg)
            IDLE: begin
                if (converter_enable_i && conversion_start_i) begin
                    state_next = WAITING;
                end
            end
            WAITING: begin
                // [R05] Start on edge
                if (tick) begin
                    state_next = CONVERT;
                    cnt_next   = `CCNT_RST;
                end
            end
            CONVERT: begin
                if (tick) begin
                    cnt_next = cnt_reg + 5'h01;
                    // [R06] Normal length count
                    // [R07] First length count
                    if ((first_reg && cnt_reg == `CONV_FIRST - 5'h01) ||
                        (!first_reg &&
                         cnt_reg == `CONV_NORMAL - 5'h01)) begin
                        state_next = IDLE;
                        first_next = 1'b0;
                        done_next  = 1'b1;
                    end
                end
            end
            default: begin
                state_next = IDLE;
            end
        endcase
        // Disabling aborts and rearms the long first conversion
        if (!converter_enable_i) begin
            state_next = IDLE;
            cnt_next   = `CCNT_RST;
            first_next = 1'b1;
            done_next  = 1'b0;
        end
    end

    // Sequencer state and registered outputs
    always @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg          <= IDLE;
            cnt_reg            <= `CCNT_RST;
            first_reg          <= 1'b1;
            conv_done_o        <= 1'b0;
            conversion_start_o <= 1'b0;
            converting_o       <= 1'b0;
            first_conv_o       <= 1'b1;
            adc_clk_o          <= 1'b0;
        end else if (clk_en_i) begin
            state_reg          <= state_next;
            cnt_reg            <= cnt_next;
            first_reg          <= first_next;
            conv_done_o        <= done_next;
            // [R09] Busy reads one
            conversion_start_o <= (state_next != IDLE);
            converting_o       <= (state_next == CONVERT);
            first_conv_o       <= first_next;
            adc_clk_o          <= tick;
        end
    end

endmodule // adc_conv_timing

// ### rtl/adc_prescaler.v
// Prescaler that makes the converter clock tick from the CPU clock
`timescale 1ns/1ns
`include "adc_timing_defines.vh"

module adc_prescaler (
    // Clock, reset and enable
    input  wire                core_clk_i,
    input  wire                sys_rst_i,
    input  wire                clk_en_i,
    // Control
    input  wire                run_i,
    input  wire [`PSEL_W-1:0]  prescale_select_i,
    // Converter clock rising edge strobe
    output reg                 tick_o
);

    reg  [`PCNT_W-1:0] count_reg;
    reg  [`PCNT_W-1:0] count_next;
    reg                tick_next;
    reg  [`PCNT_W-1:0] limit;

    // [R02] Select picks ratio
    // [R10] Ratio ladder mapping
    // Ratio ladder: code 0..7 gives 2,2,4,8,16,32,64,128
    always @* begin
        case (prescale_select_i)
            3'h0:    limit = 7'h01;
            3'h1:    limit = 7'h01;
            3'h2:    limit = 7'h03;
            3'h3:    limit = 7'h07;
            3'h4:    limit = 7'h0f;
            3'h5:    limit = 7'h1f;
            3'h6:    limit = 7'h3f;
            default: limit = 7'h7f;
        endcase
    end

    // Next count and tick, held cleared while not running
    always @* begin
        count_next = count_reg + 7'h01;
        tick_next  = 1'b0;
        if (!run_i) begin
            count_next = `PCNT_RST;
        end else if (count_reg >= limit) begin
            count_next = `PCNT_RST;
            tick_next  = 1'b1;
        end
    end

    // Counter state
    always @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            count_reg <= `PCNT_RST;
            tick_o    <= 1'b0;
        end else if (clk_en_i) begin
            count_reg <= count_next;
            tick_o    <= tick_next;
        end
    end

endmodule // adc_prescaler

// ### testbench/adc_conv_timing_assertions.sv
// Port checks on the conversion timing block
`timescale 1ns/1ns
`include "adc_timing_defines.vh"
module adc_conv_timing_assertions (
    // Clock, reset and controls
    input wire               core_clk_i,
    input wire               sys_rst_i,
    input wire               converter_enable_i,
    input wire [`PSEL_W-1:0] prescale_select_i,
    input wire               conversion_start_i,
    // Status
    input wire               conversion_start_o,
    input wire               converting_o,
    input wire               first_conv_o,
    input wire               conv_done_o,
    input wire               adc_clk_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    // Waiting for the converter clock edge that opens a conversion
    sequence s_wait_tick;
        conversion_start_o && !converting_o;
    endsequence
    // Conversion entered from waiting
    sequence s_enter;
        s_wait_tick ##1 converting_o;
    endsequence
    a_tick_held_off: assert property (!converter_enable_i [*2] |=> !adc_clk_o)
        else $error("converter clock ticks while disabled");
    a_code0_gap: assert property (adc_clk_o && !prescale_select_i |=> !adc_clk_o)
        else $error("ratio two ticks back to back");
    a_start_taken: assert property (converter_enable_i && conversion_start_i
        && !conversion_start_o |=> conversion_start_o)
        else $error("start bit not read back");
    a_busy_reads: assert property (converting_o |-> conversion_start_o)
        else $error("start bit low while converting");
    a_conv_enter: assert property (s_enter |-> adc_clk_o)
        else $error("conversion missed its clock edge");
    a_done_pulse: assert property (conv_done_o |=> !conv_done_o)
        else $error("done held too long");
    a_done_clears: assert property (conv_done_o |-> !conversion_start_o
        && !converting_o && !first_conv_o)
        else $error("status not cleared at done");
    a_done_on_tick: assert property ($rose(conv_done_o) |-> adc_clk_o)
        else $error("done away from a converter clock");
endmodule // adc_conv_timing_assertions
bind adc_conv_timing adc_conv_timing_assertions u_chk (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .converter_enable_i(converter_enable_i),
    .prescale_select_i(prescale_select_i),
    .conversion_start_i(conversion_start_i),
    .conversion_start_o(conversion_start_o), .converting_o(converting_o),
    .first_conv_o(first_conv_o), .conv_done_o(conv_done_o),
    .adc_clk_o(adc_clk_o));

// ### testbench/adc_conv_timing_test.sv
// Bench for the conversion timing block
`timescale 1ns/1ns
module adc_conv_timing_test;
    reg        clk = 1'b0, rst = 1'b1, en = 1'b0, go = 1'b0;
    reg  [2:0] psel = 3'h0;
    wire       st, busy, first, done, tick;
    wire [7:0] clocks;
    integer    failures = 0, compares = 0, cyc = 0, n, k;
    always #5 clk = ~clk;
    adc_conv_timing dut (.core_clk_i(clk), .sys_rst_i(rst), .clk_en_i(1'b1),
        .converter_enable_i(en), .prescale_select_i(psel),
        .conversion_start_i(go), .conversion_start_o(st),
        .converting_o(busy), .first_conv_o(first), .conv_done_o(done),
        .adc_clk_o(tick));
    sampling_core_model core (.core_clk_i(clk), .sys_rst_i(rst),
        .converting_i(busy), .adc_clk_i(tick), .clocks_o(clocks));
    task chk(input [7:0] seen, input [7:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("BAD %0t %h %h", $time, seen, exp);
        end
    endtask
    task step;
        @(negedge clk);
        n = n + 1;
    endtask
    // Request one conversion, then wait for done at most 900 cycles
    task convert;
        step;
        go = 1'b1;
        step;
        go = 1'b0;
        chk(st, 8'h01);
        n = 0;
        do step; while (done !== 1'b1 && n < 900);
        chk(done, 8'h01);
    endtask
    // Ratio two: first conversion counts 25 converter clocks, the next 13
    task test_conv;
        step;
        en = 1'b1;
        chk(first, 8'h01);
        convert;
        chk(clocks, 8'h19);
        convert;
        chk(clocks, 8'h0d);
        chk(first, 8'h00);
        $display("test_conv done");
    endtask
    // Disable in mid conversion, then the long one comes back
    task test_abort;
        step;
        go = 1'b1;
        repeat (9) step;
        go = 1'b0;
        en = 1'b0;
        repeat (2) step;
        chk(st, 8'h00);
        chk(first, 8'h01);
        en = 1'b1;
        convert;
        chk(clocks, 8'h19);
        $display("test_abort done");
    endtask
    // Tick spacing for every select code
    task test_ratio;
        for (k = 0; k < 8; k = k + 1) begin
            step;
            en = 1'b0;
            psel = k[2:0];
            step;
            en = 1'b1;
            n = 0;
            do step; while (tick !== 1'b1 && n < 300);
            n = 0;
            do step; while (tick !== 1'b1 && n < 300);
            chk(n[7:0], (k < 2) ? 8'h02 : 8'h01 << k);
        end
        $display("test_ratio done");
    endtask
    task final_report;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Cycle ceiling against a hang
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            failures = failures + 1;
            final_report;
        end
    end
    initial begin
        repeat (2) @(negedge clk);
        rst = 1'b0;
        test_conv;
        test_abort;
        test_ratio;
        final_report;
    end
endmodule // adc_conv_timing_test

// ### testbench/sampling_core_model.sv
// Sampling core stand-in counting converter clocks of a conversion
`timescale 1ns/1ns
module sampling_core_model (
    // Clock, reset and conversion controls
    input  wire       core_clk_i,
    input  wire       sys_rst_i,
    input  wire       converting_i,
    input  wire       adc_clk_i,
    // Clocks seen in the running conversion, cleared one cycle after it ends
    output reg  [7:0] clocks_o
);
    // Cleared once the block stops converting, so aborts leave nothing
    always @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i || !converting_i) clocks_o <= 8'h00;
        else if (adc_clk_i) clocks_o <= clocks_o + 8'h01;
    end
endmodule // sampling_core_model
